// ---- verif/spi_chan_checker.sv ----
/* Port checker for the SPI channel, bound into its top module.
 Assumes the reset divider: a half period of 4 clocks. */
`timescale 1ns/1ps
module spi_chan_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus and stream
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic tx_ready,
  // SPI pins
  input wire logic spi_clk,
  input wire logic spi_sel_n,
  input wire logic spi_mosi
);
  logic       clk_q;
  logic [3:0] rise_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // Rises per select window
  always_ff @(posedge aclk) begin
    clk_q <= spi_clk;
    if (!aresetn || spi_sel_n)
      rise_q <= 4'h0;
    else if (spi_clk && !clk_q)
      rise_q <= rise_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  a_rise_selected: assert property (
    $rose(spi_clk) |-> !spi_sel_n && $past(spi_sel_n) == 1'b0)
    else $error("clock rose while deselected");
  a_mosi_on_fall: assert property (
    $changed(spi_mosi) && !spi_sel_n && $past(spi_sel_n) == 1'b0
    |-> $fell(spi_clk)) else $error("data moved off the falling edge");
  a_first_rise: assert property (
    $fell(spi_sel_n) |-> !spi_clk [*4] ##1 spi_clk)
    else $error("first rise misplaced");
  a_high_half: assert property (
    $rose(spi_clk) |-> spi_clk [*4] ##1 !spi_clk)
    else $error("clock high phase wrong");
  a_eight_bits: assert property (
    $rose(spi_sel_n) |-> rise_q == 4'h8)
    else $error("select window without eight rises");
  a_sel_end_fall: assert property (
    $rose(spi_sel_n) |-> $fell(spi_clk))
    else $error("select rose off the last clock fall");
  a_take_selects: assert property (
    tx_ready |-> $fell(spi_sel_n) && !spi_clk)
    else $error("byte taken without select");
  a_read_answer: assert property (
    s_arready |=> s_rvalid) else $error("read answer late");
  a_idle_clock: assert property (
    spi_sel_n && $past(spi_sel_n) == 1'b1 |-> !spi_clk)
    else $error("clock moves while deselected");
endmodule

bind spi_chan spi_chan_checker chk (
  .aclk(aclk), .aresetn(aresetn), .s_arready(s_arready),
  .s_rvalid(s_rvalid), .tx_ready(tx_ready), .spi_clk(spi_clk),
  .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi));

// ---- verif/spi_slave_model.sv ----
/* SPI slave model, mode 0, bit order chosen by the bench.
 Assumes the bench queues one reply byte per transfer. */
`timescale 1ns/1ps
module spi_slave_model (
  // SPI pins and bit order select
  input wire logic  spi_clk,
  input wire logic  spi_sel_n,
  input wire logic  spi_mosi,
  input wire logic  lsb_first,
  output logic      spi_miso,
  // Bytes seen on the data line
  output logic [7:0] seen_byte,
  output logic       seen_tgl
);
  logic [7:0] resp_q[$];
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int         cnt;
  initial begin
    spi_miso = 1'b0;
    seen_tgl = 1'b0;
    seen_byte = 8'h00;
    cnt = 0;
  end
  // First bit ready as select falls
  always @(negedge spi_sel_n) begin
    tx_sh = (resp_q.size() > 0) ? resp_q.pop_front() : 8'hA5;
    spi_miso <= lsb_first ? tx_sh[0] : tx_sh[7];
    cnt = 0;
  end
  always @(negedge spi_clk) if (!spi_sel_n) begin
    tx_sh = lsb_first ? tx_sh >> 1 : tx_sh << 1;
    spi_miso <= lsb_first ? tx_sh[0] : tx_sh[7];
  end
  always @(posedge spi_clk) if (!spi_sel_n) begin
    rx_sh = lsb_first ? {spi_mosi, rx_sh[7:1]} : {rx_sh[6:0], spi_mosi};
    cnt++;
    if (cnt == 8) begin
      seen_byte = rx_sh;
      seen_tgl = ~seen_tgl;
    end
  end
  // Released line must not keep its last value
  always @(posedge spi_sel_n) spi_miso <= ~spi_miso;
endmodule

// ---- verif/tb.sv ----
/* Bench for the SPI channel: bus tasks, byte driver, result queue.
 Assumes reset divider and the slave model; bit order set per test. */
`timescale 1ns/1ps
module tb;
  localparam logic [7:0]  CA = spi_chan_pkg::CTRL_A_OFS;
  localparam logic [7:0]  CB = spi_chan_pkg::CTRL_B_OFS;
  localparam logic [7:0]  ST = spi_chan_pkg::STAT_A_OFS;
  localparam logic [7:0]  FF = spi_chan_pkg::FIFO_OFS;
  localparam logic [31:0] CE = 32'h8003_0000;
  localparam logic [33:0] SM = 34'h0_C070_0000;
  logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid;
  logic        s_rready, tx_valid, tx_ready, spi_clk, spi_sel_n;
  logic        spi_mosi, spi_miso, rx_irq, rx_dma_req, seen_tgl, lsb_first;
  logic [7:0]  s_awaddr, s_araddr, tx_byte, seen_byte;
  logic [31:0] s_wdata, s_rdata, rd_data, w_exp, m_exp;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [33:0] exp_q[$], msk_q[$];
  logic [7:0]  mosi_q[$];
  logic [1:0]  bexp_q[$];
  int          miscompares, checks, seed;

  spi_chan dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .rx_irq(rx_irq),
    .rx_dma_req(rx_dma_req));
  spi_slave_model slv (.spi_clk(spi_clk), .spi_sel_n(spi_sel_n),
    .spi_mosi(spi_mosi), .lsb_first(lsb_first), .spi_miso(spi_miso),
    .seen_byte(seen_byte), .seen_tgl(seen_tgl));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [33:0] got, exp, msk, input string s);
    checks++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Results taken in bus order, so the oldest note matches
  always @(posedge aclk) begin
    if (s_rvalid && s_rready && exp_q.size() > 0)
      cmp({s_rresp, s_rdata}, exp_q.pop_front(), msk_q.pop_front(),
          "rd");
  end
  always @(posedge aclk) begin
    if (s_bvalid && s_bready && bexp_q.size() > 0)
      cmp({32'h0, s_bresp}, {32'h0, bexp_q.pop_front()}, 34'h3, "wr");
  end
  always @(seen_tgl) begin
    if (mosi_q.size() > 0)
      cmp({26'h0, seen_byte}, {26'h0, mosi_q.pop_front()}, 34'hFF,
          "tx");
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bexp_q.push_back(a > spi_chan_pkg::IRQ_LINE_OFS
                     ? spi_chan_pkg::RESP_SLVERR : spi_chan_pkg::RESP_OKAY);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    rd_data = s_rdata;
    s_rready <= 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    mosi_q.push_back(b);
    @(posedge aclk);
    tx_byte <= b;
    tx_valid <= 1'b1;
    do begin
      @(posedge aclk);
    end while (!tx_ready);
    tx_valid <= 1'b0;
  endtask
  task automatic cfg(input logic [31:0] c, bg, cg);
    wr(CA, 32'h0);
    wr(spi_chan_pkg::BGAP_OFS, bg);
    wr(spi_chan_pkg::CGAP_OFS, cg);
    wr(CB, c);
    wr(CA, CE);
  endtask
  // Random bytes out, random replies packed by the endian choice
  task automatic load(input int n, input logic big);
    logic [7:0] r;
    int         p;
    w_exp = 32'h0;
    m_exp = 32'h0;
    for (int i = 0; i < n; i++) begin
      r = 8'($random(seed));
      p = big ? 24 - 8 * i : 8 * i;
      w_exp |= 32'(r) << p;
      m_exp |= 32'h0000_00FF << p;
      slv.resp_q.push_back(r);
      send(8'($random(seed)));
    end
    do begin
      rd(ST, 34'h0, 34'h0);
    end while (rd_data[n == 4 ? 31 : 30] !== 1'b1);
  endtask
  task automatic drain(input int n);
    logic [33:0] s;
    s = {2'b00, 32'h8000_0000 | (32'(n) << 20)};
    if (n < 4) begin
      rd(ST, 34'h4000_0000, SM);
      rd(FF, 34'h0, 34'h3_FFFF_FFFF);
      wr(ST, 32'h4000_0000);
    end
    rd(ST, s, SM);
    rd(FF, {2'b00, w_exp}, {2'b11, m_exp});
    rd(ST, 34'h0, SM);
    $display("test of %0d bytes done", n);
  endtask
  task automatic lines(input logic [1:0] e);
    repeat (2) @(posedge aclk);
    cmp({32'h0, rx_dma_req, rx_irq}, {32'h0, e}, 34'h3, "lines");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h269a;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, tx_valid} = 6'h00;
    s_awaddr = 8'h00;
    s_araddr = 8'h00;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    tx_byte = 8'h00;
    lsb_first = 1'b0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CA, 34'h0, 34'h3_FFFF_FFFF);
    rd(spi_chan_pkg::BRATE_OFS, 34'h3, 34'h3_FFFF_FFFF);
    rd(FF, 34'h0, 34'h3_FFFF_FFFF);
    rd(8'h20, {spi_chan_pkg::RESP_SLVERR, 32'h0}, 34'h3_0000_0000);
    wr(8'h20, 32'h0);
    $display("test of reset values done");
    cfg(32'h0024_0000, 32'h0, 32'h0);
    load(4, 1'b1);
    wr(spi_chan_pkg::IRQ_LINE_OFS, 32'h1);
    wr(CA, CE | 32'h0080_0000);
    lines(2'b01);
    wr(spi_chan_pkg::IRQ_LINE_OFS, 32'h0);
    lines(2'b00);
    wr(CA, CE | 32'h0020_0000);
    lines(2'b10);
    wr(CA, CE);
    drain(4);
    cfg(32'h4020_0000, 32'h0, 32'h4);
    load(2, 1'b0);
    drain(2);
    lsb_first <= 1'b1;
    cfg(32'h802C_0000, 32'd20, 32'h0);
    load(3, 1'b1);
    drain(3);
    summarize();
  end
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
endmodule

// ---- verilog/spi_chan.sv ----
/*
 SPI master channel with receive word FIFO behind an AXI4-Lite slave.
 Assumes one 50 MHz clock; the transmit byte source is a valid/ready
 stream from the transmit FIFO outside; the slave input is asynchronous.
*/
`timescale 1ns/1ps
module spi_chan #(
  parameter int DMA_CHANNEL = 7
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  // Transmit byte stream
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // SPI pins
  output logic             spi_clk,
  output logic             spi_sel_n,
  output logic             spi_mosi,
  input  wire logic        spi_miso,
  // Interrupt and DMA request
  output logic             rx_irq,
  output logic             rx_dma_req
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_a_q, ctrl_b_q, brate_q, bgap_q, cgap_q;
  logic        line_en_q;
  logic [31:0] fifo_mem [spi_chan_pkg::RX_DEPTH];
  logic [2:0]  fifo_cnt_mem [spi_chan_pkg::RX_DEPTH];
  logic [spi_chan_pkg::RX_AW:0] wp_q, rp_q;
  logic        closed_q;
  logic [31:0] pack_q;
  logic [2:0]  npack_q;
  logic        miso_s1_q, miso_s2_q;
  spi_chan_pkg::spi_state_t st_q;
  logic [14:0] div_q;
  logic [2:0]  bit_q;
  logic [7:0]  sh_tx_q, sh_rx_q;
  logic [31:0] bgap_cnt_q, cgap_cnt_q;
  logic [5:0]  tick_q;
  logic        bgap_run_q, cgap_run_q;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  ////////////////////////////////////////////////////////////////////////
  wire enabled   = ctrl_a_q[spi_chan_pkg::CA_CE];
  // Slave mode code idles the engine; no slave path here
  wire master    = ctrl_b_q[spi_chan_pkg::CB_MODE_LO +: 2]
                   == spi_chan_pkg::MODE_MASTER;
  wire run       = enabled && master;
  wire big_end   = ctrl_b_q[spi_chan_pkg::CB_BIG_END];
  wire lsb_first = ctrl_b_q[spi_chan_pkg::CB_BITORD];
  wire fifo_empty = wp_q == rp_q;
  wire fifo_full  = wp_q == {~rp_q[spi_chan_pkg::RX_AW],
                             rp_q[spi_chan_pkg::RX_AW-1:0]};
  wire rx_rdy     = !fifo_empty && !closed_q;
  wire [2:0] head_cnt = fifo_cnt_mem[rp_q[spi_chan_pkg::RX_AW-1:0]];
  wire div_hit    = div_q == brate_q[spi_chan_pkg::BR_DIV_W-1:0];
  wire tick       = tick_q == 6'(spi_chan_pkg::TICK_CYC - 1);

  // Byte completion and packing
  wire        rx_rise   = (st_q == spi_chan_pkg::SPI_LOW) && div_hit;
  wire [7:0]  rx_next   = lsb_first ? {miso_s2_q, sh_rx_q[7:1]}
                                    : {sh_rx_q[6:0], miso_s2_q};
  wire        byte_done = rx_rise && bit_q == 3'h7;
  wire [1:0]  slot      = npack_q[1:0];
  wire [31:0] pack_ins  = big_end
                          ? (pack_q | ({24'h0, rx_next} << (5'(3 - slot) * 8)))
                          : (pack_q | ({24'h0, rx_next} << (5'(slot) * 8)));
  wire        bgap_exp  = bgap_run_q && tick && bgap_cnt_q == 32'h1;
  wire        cgap_exp  = cgap_run_q && tick && cgap_cnt_q == 32'h1;
  wire        flush     = (bgap_exp || cgap_exp) && npack_q != 3'h0;
  wire        push_full = byte_done && npack_q == 3'h3;
  wire        push      = (push_full || (flush && !byte_done)) && !fifo_full;

  // AXI decode
  wire wr_go   = aw_q && w_q && !s_bvalid;
  wire rd_go   = s_arvalid && s_arready;
  wire rd_fifo = rd_go && s_araddr == spi_chan_pkg::FIFO_OFS;
  wire pop     = rd_fifo && rx_rdy;
  wire bc_wr   = wr_go && awaddr_q == spi_chan_pkg::STAT_A_OFS
                 && wdata_q[spi_chan_pkg::SA_BC];
  // Count field reads zero while no word is ready
  wire [31:0] stat_a = {rx_rdy, closed_q, tx_valid, 6'h0,
                        (rx_rdy ? head_cnt : 3'h0), 20'h0};
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    unique case (s_araddr)
      spi_chan_pkg::CTRL_A_OFS:   rd_val = ctrl_a_q;
      spi_chan_pkg::CTRL_B_OFS:   rd_val = ctrl_b_q;
      spi_chan_pkg::STAT_A_OFS:   rd_val = stat_a;
      spi_chan_pkg::BRATE_OFS:    rd_val = brate_q;
      spi_chan_pkg::FIFO_OFS:
        rd_val = pop ? fifo_mem[rp_q[spi_chan_pkg::RX_AW-1:0]] : 32'h0;
      spi_chan_pkg::BGAP_OFS:     rd_val = bgap_q;
      spi_chan_pkg::CGAP_OFS:     rd_val = cgap_q;
      spi_chan_pkg::IRQ_LINE_OFS: rd_val = {31'h0, line_en_q};
      default:                    rd_ok  = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= spi_chan_pkg::RESP_OKAY;
    end else begin
      s_awready <= !aw_q && !s_awready && s_awvalid;
      s_wready <= !w_q && !s_wready && s_wvalid;
      if (s_awvalid && s_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= (awaddr_q > spi_chan_pkg::IRQ_LINE_OFS)
                   ? spi_chan_pkg::RESP_SLVERR : spi_chan_pkg::RESP_OKAY;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Registers; partial strobes ignored, word writes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= spi_chan_pkg::CTRL_A_RST;
      ctrl_b_q <= spi_chan_pkg::CTRL_B_RST;
      brate_q <= spi_chan_pkg::BRATE_RST;
      bgap_q <= 32'h0;
      cgap_q <= 32'h0;
      line_en_q <= 1'b0;
    end else if (wr_go && wstrb_q == 4'hF) begin
      unique case (awaddr_q)
        spi_chan_pkg::CTRL_A_OFS:   ctrl_a_q <= wdata_q;
        spi_chan_pkg::CTRL_B_OFS:   ctrl_b_q <= wdata_q;
        spi_chan_pkg::BRATE_OFS:    brate_q <= wdata_q;
        spi_chan_pkg::BGAP_OFS:     bgap_q <= wdata_q;
        spi_chan_pkg::CGAP_OFS:     cgap_q <= wdata_q;
        spi_chan_pkg::IRQ_LINE_OFS: line_en_q <= wdata_q[0];
        default: ;
      endcase
    end
  end

  // AXI read channel, one cycle answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= spi_chan_pkg::RESP_OKAY;
    end else begin
      s_arready <= !s_arready && !s_rvalid && s_arvalid;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_val;
        s_rresp <= rd_ok ? spi_chan_pkg::RESP_OKAY
                         : spi_chan_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive FIFO; channel disable empties it
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) begin
        fifo_mem[wp_q[spi_chan_pkg::RX_AW-1:0]] <=
          push_full ? pack_ins : pack_q;
        fifo_cnt_mem[wp_q[spi_chan_pkg::RX_AW-1:0]] <=
          push_full ? 3'h4 : npack_q;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end

  // Closed flag: set wins over the software clear
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) closed_q <= 1'b0;
    else if (flush && push) closed_q <= 1'b1;
    else if (bc_wr) closed_q <= 1'b0;
  end

  // Packing register
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      pack_q <= 32'h0;
      npack_q <= 3'h0;
    end else if (push) begin
      pack_q <= 32'h0;
      npack_q <= 3'h0;
    end else if (byte_done && npack_q != 3'h4) begin
      pack_q <= pack_ins;
      npack_q <= npack_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Gap timers in microsecond ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || !enabled) begin
      tick_q <= 6'h0;
      bgap_run_q <= 1'b0;
      cgap_run_q <= 1'b0;
      bgap_cnt_q <= 32'h0;
      cgap_cnt_q <= 32'h0;
    end else begin
      tick_q <= tick ? 6'h0 : tick_q + 6'h1;
      if (byte_done && npack_q == 3'h0 && !bgap_run_q) begin
        bgap_run_q <= ctrl_b_q[spi_chan_pkg::CB_BGT_ON];
        bgap_cnt_q <= bgap_q;
      end else if (push) begin
        bgap_run_q <= 1'b0;
      end else if (bgap_run_q && tick) begin
        bgap_cnt_q <= bgap_cnt_q - 32'h1;
      end
      if (byte_done) begin
        cgap_run_q <= ctrl_b_q[spi_chan_pkg::CB_CGT_ON];
        cgap_cnt_q <= cgap_q;
      end else if (push) begin
        cgap_run_q <= 1'b0;
      end else if (cgap_run_q && tick) begin
        cgap_cnt_q <= cgap_cnt_q - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // SPI master engine; each half period is divider+1 clocks
  always_ff @(posedge aclk) begin
    miso_s1_q <= spi_miso;
    miso_s2_q <= miso_s1_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      st_q <= spi_chan_pkg::SPI_IDLE;
      div_q <= 15'h0;
      bit_q <= 3'h0;
      sh_tx_q <= 8'h0;
      sh_rx_q <= 8'h0;
      spi_clk <= 1'b0;
      spi_sel_n <= 1'b1;
      spi_mosi <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= 1'b0;
      div_q <= div_hit ? 15'h0 : div_q + 15'h1;
      unique case (st_q)
        spi_chan_pkg::SPI_IDLE: begin
          spi_sel_n <= 1'b1;
          div_q <= 15'h0;
          if (tx_valid && !tx_ready && !fifo_full) begin
            tx_ready <= 1'b1;
            sh_tx_q <= lsb_first ? {1'b0, tx_byte[7:1]}
                                 : {tx_byte[6:0], 1'b0};
            spi_mosi <= lsb_first ? tx_byte[0] : tx_byte[7];
            spi_sel_n <= 1'b0;
            bit_q <= 3'h0;
            st_q <= spi_chan_pkg::SPI_LOW;
          end
        end
        spi_chan_pkg::SPI_LOW: if (div_hit) begin
          spi_clk <= 1'b1;
          sh_rx_q <= rx_next;
          st_q <= (bit_q == 3'h7) ? spi_chan_pkg::SPI_DONE
                                  : spi_chan_pkg::SPI_HIGH;
        end
        spi_chan_pkg::SPI_HIGH: if (div_hit) begin
          spi_clk <= 1'b0;
          spi_mosi <= lsb_first ? sh_tx_q[0] : sh_tx_q[7];
          sh_tx_q <= lsb_first ? {1'b0, sh_tx_q[7:1]}
                               : {sh_tx_q[6:0], 1'b0};
          bit_q <= bit_q + 3'h1;
          st_q <= spi_chan_pkg::SPI_LOW;
        end
        spi_chan_pkg::SPI_DONE: if (div_hit) begin
          spi_clk <= 1'b0;
          spi_sel_n <= 1'b1;
          st_q <= spi_chan_pkg::SPI_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt and DMA request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_irq <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      rx_irq <= line_en_q &&
                ((rx_rdy && ctrl_a_q[spi_chan_pkg::CA_RDY_IE]) ||
                 (closed_q && ctrl_a_q[spi_chan_pkg::CA_BC_IE]));
      rx_dma_req <= rx_rdy && ctrl_a_q[spi_chan_pkg::CA_RX_DMA];
    end
  end

endmodule

// ---- verilog/spi_chan_pkg.sv ----
/*
 Constants for the serial SPI channel: register map, field positions,
 reset values, timing and enumerations.
 Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package spi_chan_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_A_OFS   = 8'h00;
  localparam logic [7:0] CTRL_B_OFS   = 8'h04;
  localparam logic [7:0] STAT_A_OFS   = 8'h08;
  localparam logic [7:0] BRATE_OFS    = 8'h0C;
  localparam logic [7:0] FIFO_OFS     = 8'h10;
  localparam logic [7:0] BGAP_OFS     = 8'h14;
  localparam logic [7:0] CGAP_OFS     = 8'h18;
  localparam logic [7:0] IRQ_LINE_OFS = 8'h1C;

  // Control A fields
  localparam int CA_CE       = 31;
  localparam int CA_RDY_IE   = 23;
  localparam int CA_BC_IE    = 22;
  localparam int CA_RX_DMA   = 21;
  localparam int CA_WLS_LO   = 16;

  // Control B fields
  localparam int CB_BGT_ON   = 31;
  localparam int CB_CGT_ON   = 30;
  localparam int CB_MODE_LO  = 20;
  localparam int CB_BITORD   = 19;
  localparam int CB_BIG_END  = 18;

  // Status A fields
  localparam int SA_RDY      = 31;
  localparam int SA_BC       = 30;
  localparam int SA_NBYTE_LO = 20;
  localparam int SA_TX_RDY   = 29;

  // Bit-rate register: divider in low bits
  localparam int BR_DIV_W    = 15;

  // Mode encodings
  localparam logic [1:0] MODE_MASTER = 2'h2;
  localparam logic [1:0] MODE_SLAVE  = 2'h3;

  // Reset values
  localparam logic [31:0] CTRL_A_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_B_RST = 32'h0000_0000;
  localparam logic [31:0] BRATE_RST  = 32'h0000_0003;

  // FIFO geometry: 32 bytes as eight words
  localparam int          RX_DEPTH   = 8;
  localparam int          RX_AW      = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Gap timers count in microsecond ticks
  localparam int TICK_NS    = 1000;
  localparam int CLK_NS     = 20;
  localparam int TICK_CYC   = TICK_NS / CLK_NS;

  typedef enum logic [1:0] {
    SPI_IDLE  = 2'b00,
    SPI_LOW   = 2'b01,
    SPI_HIGH  = 2'b10,
    SPI_DONE  = 2'b11
  } spi_state_t;

endpackage
